// File: recal_host.sv
// Host and frame source on the scheduler's far side
`timescale 1ns/1ps
module recal_host (
	input wire logic	clk_sys,	// Clock
	input wire logic	recal_wanted_flag,	// Flag to serve
	input wire logic	serve_en,	// Serving allowed
	output logic	frame_strobe,	// Sensor frame pin
	output logic	host_cmd	// Command pulse
);
	// ********
	// Frame source and flag service
	// ********
	// Frames run free, phase unrelated to the clock
	initial frame_strobe = 1'b0;
	always begin
		#43 frame_strobe = 1'b1;
		#40 frame_strobe = 1'b0;
	end
	initial host_cmd = 1'b0;
	always @(negedge clk_sys) begin
		if (serve_en && recal_wanted_flag) begin
			repeat (4) @(negedge clk_sys);
			host_cmd <= 1'b1;
			@(negedge clk_sys);
			host_cmd <= 1'b0;
			// Hold off so one flag gives one event
			repeat (300) @(negedge clk_sys);
		end
	end
endmodule

// File: recal_monitor.sv
// Assertion checker for the recalibration scheduler ports
`timescale 1ns/1ps
module recal_monitor
	import recal_pkg::*;
(
	input wire logic	clk_sys,	// Clock
	input wire logic	rst,	// Reset
	input wire logic [1:0]	policy_in,	// Policy code
	input wire logic	policy_we,	// Policy load
	input wire logic [1:0]	frames_in,	// Frame code
	input wire logic	frames_we,	// Frame load
	input wire recal_policy_t	recal_policy,	// Policy
	input wire logic [FRAME_W-1:0]	recal_frame_count,	// Frames
	input wire logic	recal_pending_warning,	// Warning
	input wire recal_phase_t	recal_phase,	// Phase
	input wire logic	recal_wanted_flag,	// Wanted
	input wire logic	shutter_close,	// Shutter
	input wire logic	capture_en,	// Capture
	input wire logic	terms_update	// Update
);
	// ********
	// Helper count and assertions
	// ********
	localparam int LIM = 520;
	logic [5:0]	caps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Frames taken so far in the running event
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			caps <= 6'h00;
		else if (recal_phase != PH_IN_PROGRESS)
			caps <= 6'h00;
		else if (capture_en)
			caps <= caps + 6'h01;
	end
	sequence warn_end;
		$fell(recal_pending_warning);
	endsequence
	sequence cap_start;
		$rose(shutter_close);
	endsequence
	policy_load_a: assert property (
		policy_we && policy_in != 2'h3 |=> recal_policy == $past(policy_in))
		else $error("policy not loaded");
	frames_load_a: assert property (
		frames_we |=> recal_frame_count == (5'h02 << $past(frames_in)))
		else $error("frame count not decoded");
	frame_limit_a: assert property (caps <= recal_frame_count)
		else $error("too many frames taken");
	capture_phase_a: assert property (
		capture_en |-> recal_phase == PH_IN_PROGRESS)
		else $error("capture outside event");
	warn_phase_a: assert property (
		recal_pending_warning |-> recal_phase == PH_IMMINENT)
		else $error("warning without imminent phase");
	warn_capture_a: assert property (warn_end |-> ##[0:3] shutter_close)
		else $error("warning not followed by capture");
	wanted_auto_a: assert property (
		$rose(recal_wanted_flag) |-> recal_policy != POL_AUTO)
		else $error("wanted flag in automatic policy");
	event_bound_a: assert property (cap_start |-> ##[1:LIM] terms_update)
		else $error("event did not finish");
endmodule

bind recal_scheduler recal_monitor mon (.clk_sys(clk_sys), .rst(rst),
	.policy_in(policy_in), .policy_we(policy_we), .frames_in(frames_in),
	.frames_we(frames_we), .recal_policy(recal_policy),
	.recal_frame_count(recal_frame_count),
	.recal_pending_warning(recal_pending_warning),
	.recal_phase(recal_phase), .recal_wanted_flag(recal_wanted_flag),
	.shutter_close(shutter_close), .capture_en(capture_en),
	.terms_update(terms_update));

// File: recal_pkg.sv
// Package: constants and types for the recalibration scheduler
package recal_pkg;

	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int unsigned CLK_HZ             = 100_000_000;
	localparam int unsigned SEC_CYCLES         = CLK_HZ;
	localparam int unsigned INTERVAL_S_RESET   = 300;
	localparam int unsigned WARMUP_S_RESET     = 90;
	localparam int unsigned WARN_S_RESET       = 2;
	localparam int unsigned EVENT_LIMIT_MS     = 1000;
	localparam int unsigned EVENT_LIMIT_CYCLES =
		EVENT_LIMIT_MS * (CLK_HZ / 1000) - 1;

	// ************************************************
	// Field widths and reset values
	// ************************************************
	localparam int SEC_W   = 16;
	localparam int TEMP_W  = 16;
	localparam int FRAME_W = 5;
	localparam logic [15:0] TEMP_STEP_RESET = 16'h000a;
	localparam logic [4:0]  FRAMES_SHUTTER  = 5'h08;
	localparam logic [4:0]  FRAMES_NOSHUT   = 5'h10;

	// Frame count codes: 2, 4, 8 or 16 frames
	typedef enum logic [1:0] {
		FC_2, FC_4, FC_8, FC_16
	} frame_code_t;

	typedef enum logic [1:0] {
		POL_AUTO, POL_MANUAL, POL_EXTERNAL
	} recal_policy_t;

	// Reported phase
	typedef enum logic [1:0] {
		PH_NEVER, PH_IMMINENT, PH_IN_PROGRESS, PH_COMPLETE
	} recal_phase_t;

	// Per gain-state trigger settings
	typedef struct packed {
		logic [SEC_W-1:0]  interval_s;
		logic [TEMP_W-1:0] temp_step;
	} gain_cfg_t;

endpackage

// File: recal_scheduler.sv
// Recalibration scheduler: triggers, warning, frame capture and status
// Behaviour
// - Three policies: automatic, manual, external; set self-start, shutter.
// - Auto starts on start-up, interval, temp step, table change, command.
// - Shutterless defaults to external and never starts events itself.
// - Each event accumulates 2, 4, 8 or 16 frames.
// - Frame count resets to 8 with shutter, 16 without.
// - With averaging, each counted frame lasts a doubled frame period.
// - Interval in s, default 300; bounds auto events, else raises flag.
// - Interval of zero disables the time trigger.
// - Separate interval and step settings per gain state; active one applies.
// - Temp step triggers auto event, or wanted flag in other policies.
// - Step in tenths of a degree, default 10.
// - Step of zero disables the temperature trigger.
// - During warm-up window, default 90 s, trigger on a third of step.
// - Before each automatic event, warn for configurable time, default 2 s.
// - Report phase: never, imminent, in progress, complete.
// - Wanted flag in manual or external, and in auto when shutterless; auto with shutter starts events instead.
// - Capture ends within one second at most; one update cycle follows.
`timescale 1ns/1ps
module recal_scheduler
	import recal_pkg::*;
#(
	parameter int unsigned TICK_DIV     = SEC_CYCLES,
	parameter int unsigned EVENT_LIMIT  = EVENT_LIMIT_CYCLES,
	parameter bit          HAS_SHUTTER  = 1'b1
) (
	input  wire logic          clk_sys,          // System clock
	input  wire logic          rst,              // Async reset
	input  wire logic [1:0]    policy_in,        // Policy to load
	input  wire logic          policy_we,        // Load policy
	input  wire logic [1:0]    frames_in,        // Frame code to load
	input  wire logic          frames_we,        // Load frame code
	input  wire gain_cfg_t     cfg_high,         // High-gain settings
	input  wire gain_cfg_t     cfg_low,          // Low-gain settings
	input  wire logic [SEC_W-1:0] warmup_window_s, // Warm-up window
	input  wire logic [SEC_W-1:0] pre_recal_warning_time, // Warning s
	input  wire logic          gain_high,        // Active gain is high
	input  wire logic [TEMP_W-1:0] sensor_temp,  // Temp, 0.1 C units
	input  wire logic          table_change,     // Table change pulse
	input  wire logic          recal_cmd,        // Command event pulse
	input  wire logic          frame_strobe,     // Pin: frame done
	input  wire logic          avg_enable,       // Averager on
	output recal_policy_t      recal_policy,     // Active policy
	output logic [FRAME_W-1:0] recal_frame_count, // Frames per event
	output logic               recal_pending_warning, // Imminent
	output recal_phase_t       recal_phase,      // Phase status
	output logic               recal_wanted_flag, // Host should act
	output logic               shutter_close,    // Shutter in path
	output logic               capture_en,       // Accumulate frame
	output logic               terms_update      // Update pulse
);

	// ************************************************
	// Types and helpers
	// ************************************************
	typedef enum logic [2:0] {
		S_IDLE, S_WARN, S_CAPTURE, S_UPDATE
	} sched_state_t;

	function automatic logic [FRAME_W-1:0] frames_of(frame_code_t c);
		unique case (c)
			FC_2:  frames_of = 5'h02;
			FC_4:  frames_of = 5'h04;
			FC_8:  frames_of = 5'h08;
			FC_16: frames_of = 5'h10;
		endcase
	endfunction

	function automatic logic [TEMP_W-1:0] abs_diff(
		logic [TEMP_W-1:0] a, logic [TEMP_W-1:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	// ************************************************
	// Pin synchroniser and frame edge
	// ************************************************
	logic frame_meta;
	logic frame_sync;
	logic frame_last;
	logic frame_edge;
	logic frame_half;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frame_meta <= 1'b0;
			frame_sync <= 1'b0;
			frame_last <= 1'b0;
		end else begin
			frame_meta <= frame_strobe;
			frame_sync <= frame_meta;
			frame_last <= frame_sync;
		end
	end

	// doubled frame period
	// With the averager on, only every second raw frame counts.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			frame_half <= 1'b0;
		else if (!avg_enable)
			frame_half <= 1'b0;
		else if (frame_sync && !frame_last)
			frame_half <= ~frame_half;
	end
	assign frame_edge = frame_sync && !frame_last &&
		(!avg_enable || frame_half);

	// ************************************************
	// Seconds tick
	// ************************************************
	logic tick;

	sec_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (tick)
	);

	// ************************************************
	// Configuration
	// ************************************************
	frame_code_t frame_code;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			recal_policy <= HAS_SHUTTER ? POL_AUTO : POL_EXTERNAL;
		else if (policy_we && policy_in != 2'h3)
			recal_policy <= recal_policy_t'(policy_in);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			frame_code <= HAS_SHUTTER ? FC_8 : FC_16;
		else if (frames_we)
			frame_code <= frame_code_t'(frames_in);
	end
	assign recal_frame_count = frames_of(frame_code);

	gain_cfg_t active_cfg;
	assign active_cfg = gain_high ? cfg_high : cfg_low;

	// ************************************************
	// Timers and triggers
	// ************************************************
	sched_state_t state;
	logic [SEC_W-1:0]  since_s;
	logic [SEC_W-1:0]  uptime_s;
	logic [SEC_W-1:0]  warn_s;
	logic [TEMP_W-1:0] temp_ref;
	logic              startup_due;
	logic              done;
	logic              in_warmup;
	logic [TEMP_W-1:0] step_eff;
	logic              time_trig;
	logic              temp_trig;
	logic              cond_trig;
	logic              is_auto;

	assign is_auto = (recal_policy == POL_AUTO) && HAS_SHUTTER;
	assign done    = (state == S_UPDATE);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			since_s <= '0;
		else if (done)
			since_s <= '0;
		else if (tick && since_s != '1)
			since_s <= since_s + 1'b1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			uptime_s <= '0;
		else if (tick && uptime_s != '1)
			uptime_s <= uptime_s + 1'b1;
	end

	// temperature reference
	// Reference is taken at completion, so start-up takes the first one.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			temp_ref <= '0;
		else if (done)
			temp_ref <= sensor_temp;
	end

	assign in_warmup = uptime_s < warmup_window_s;
	assign step_eff  = in_warmup ? active_cfg.temp_step / 16'h0003
		: active_cfg.temp_step;

	assign time_trig = (active_cfg.interval_s != '0) &&
		(since_s >= active_cfg.interval_s);

	// temperature trigger
	// A step of 1 or 2 during warm-up still triggers on any change.
	assign temp_trig = (active_cfg.temp_step != '0) && !startup_due &&
		(abs_diff(sensor_temp, temp_ref) >=
		 ((step_eff == '0) ? 16'h0001 : step_eff));

	assign cond_trig = time_trig || temp_trig;

	// ************************************************
	// Sequencer
	// ************************************************
	logic [FRAME_W-1:0] frames_done;
	logic [31:0]        ev_cycles;
	logic               auto_go;

	assign auto_go = is_auto &&
		(startup_due || cond_trig || table_change);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			startup_due <= 1'b1;
		else if (done || !is_auto)
			startup_due <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (recal_cmd)
						state <= S_CAPTURE;
					else if (auto_go)
						state <= (pre_recal_warning_time == '0)
							? S_CAPTURE : S_WARN;
				end
				S_WARN: begin
					if (recal_cmd)
						state <= S_CAPTURE;
					else if (tick && warn_s + 1'b1 >=
						pre_recal_warning_time)
						state <= S_CAPTURE;
				end
				S_CAPTURE: begin
					if (frame_edge && frames_done + 1'b1 >=
						recal_frame_count)
						state <= S_UPDATE;
					else if (ev_cycles >= 32'(EVENT_LIMIT))
						state <= S_UPDATE;
				end
				S_UPDATE:
					state <= S_IDLE;
				default:
					state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			warn_s <= '0;
		else if (state != S_WARN)
			warn_s <= '0;
		else if (tick)
			warn_s <= warn_s + 1'b1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frames_done <= '0;
			ev_cycles   <= 32'h0;
		end else if (state != S_CAPTURE) begin
			frames_done <= '0;
			ev_cycles   <= 32'h0;
		end else begin
			ev_cycles <= ev_cycles + 32'h1;
			if (frame_edge)
				frames_done <= frames_done + 1'b1;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	logic ever_done;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			ever_done <= 1'b0;
		else if (done)
			ever_done <= 1'b1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			recal_phase           <= PH_NEVER;
			recal_pending_warning <= 1'b0;
			capture_en            <= 1'b0;
			terms_update          <= 1'b0;
			shutter_close         <= 1'b0;
		end else begin
			recal_pending_warning <= (state == S_WARN);
			capture_en            <= (state == S_CAPTURE) && frame_edge;
			terms_update          <= done;
			// shutter only in auto and manual
			shutter_close <= HAS_SHUTTER &&
				(recal_policy != POL_EXTERNAL) &&
				(state == S_CAPTURE);
			if (state == S_WARN)
				recal_phase <= PH_IMMINENT;
			else if (state == S_CAPTURE || done)
				recal_phase <= PH_IN_PROGRESS;
			else if (ever_done)
				recal_phase <= PH_COMPLETE;
			else
				recal_phase <= PH_NEVER;
		end
	end

	// wanted flag
	// The trigger at completion is stale; one still true after the
	// restart sets the flag again on the next cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			recal_wanted_flag <= 1'b0;
		else if (is_auto)
			recal_wanted_flag <= 1'b0;
		else if (cond_trig && !done)
			recal_wanted_flag <= 1'b1;
		else if (done)
			recal_wanted_flag <= 1'b0;
	end

endmodule

// File: recal_scheduler_tb.sv
// Self-checking bench for the recalibration scheduler
`timescale 1ns/1ps
module recal_scheduler_tb;
	import recal_pkg::*;
	logic	clk_sys, rst, policy_we, frames_we, gain_high, table_change;
	logic	cmd_tb, host_cmd, recal_cmd, frame_strobe, avg_enable;
	logic	serve_en, saw_warn, saw_shut, recal_pending_warning;
	logic	recal_wanted_flag, shutter_close, capture_en, terms_update;
	logic [1:0]	policy_in, frames_in;
	logic [15:0]	sensor_temp;
	logic [FRAME_W-1:0]	recal_frame_count, ns_frames;
	gain_cfg_t	cfg_high, cfg_low;
	recal_policy_t	recal_policy, ns_policy;
	recal_phase_t	recal_phase, ns_phase;
	int	num_errors, n_checks, caps, n, c, d[5];
	assign recal_cmd = cmd_tb | host_cmd;
	always #5 clk_sys = ~clk_sys;
	// Event evidence gathered each clock
	always @(posedge clk_sys) begin
		caps += int'(capture_en === 1'b1);
		saw_warn |= (recal_pending_warning === 1'b1);
		saw_shut |= (shutter_close === 1'b1);
	end
	recal_scheduler #(.TICK_DIV(10), .EVENT_LIMIT(500)) dut (
		.clk_sys(clk_sys), .rst(rst), .policy_in(policy_in),
		.policy_we(policy_we), .frames_in(frames_in), .frames_we(frames_we),
		.cfg_high(cfg_high), .cfg_low(cfg_low), .warmup_window_s(16'h005a),
		.pre_recal_warning_time(16'h0002), .gain_high(gain_high),
		.sensor_temp(sensor_temp), .table_change(table_change),
		.recal_cmd(recal_cmd), .frame_strobe(frame_strobe),
		.avg_enable(avg_enable), .recal_policy(recal_policy),
		.recal_frame_count(recal_frame_count),
		.recal_pending_warning(recal_pending_warning),
		.recal_phase(recal_phase), .recal_wanted_flag(recal_wanted_flag),
		.shutter_close(shutter_close), .capture_en(capture_en),
		.terms_update(terms_update));
	recal_host host (.clk_sys(clk_sys), .recal_wanted_flag(recal_wanted_flag),
		.serve_en(serve_en), .frame_strobe(frame_strobe), .host_cmd(host_cmd));
	// Shutterless build, never commanded: must stay idle on its own
	recal_scheduler #(.TICK_DIV(10), .EVENT_LIMIT(500), .HAS_SHUTTER(1'b0))
	dut_ns (
		.clk_sys(clk_sys), .rst(rst), .policy_in(2'h0), .policy_we(1'b0),
		.frames_in(2'h0), .frames_we(1'b0), .cfg_high(cfg_high),
		.cfg_low(cfg_low), .warmup_window_s(16'h005a),
		.pre_recal_warning_time(16'h0002), .gain_high(gain_high),
		.sensor_temp(sensor_temp), .table_change(table_change),
		.recal_cmd(1'b0), .frame_strobe(frame_strobe),
		.avg_enable(avg_enable), .recal_policy(ns_policy),
		.recal_frame_count(ns_frames), .recal_pending_warning(),
		.recal_phase(ns_phase), .recal_wanted_flag(),
		.shutter_close(), .capture_en(), .terms_update());
	// ********
	// Access tasks
	// ********
	task check(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task wr(input logic pol, input logic [1:0] v);
		@(negedge clk_sys);
		{policy_in, frames_in, policy_we, frames_we} = {v, v, pol, !pol};
		@(negedge clk_sys);
		{policy_we, frames_we} = 2'b00;
		@(negedge clk_sys);
	endtask
	// Bounded so a lost event cannot hang the run
	task wait_upd(output int k);
		k = 0;
		while (terms_update !== 1'b1 && k < 2000) begin
			@(posedge clk_sys);
			#1 k++;
		end
		if (k == 2000) check(16'h0000, 16'h0001, "no update");
	endtask
	// Commands are refused while an event ends, so let it settle first
	task run_event(output int k);
		repeat (3) @(negedge clk_sys);
		{saw_warn, saw_shut, caps, cmd_tb} = '0;
		cmd_tb = 1'b1;
		@(negedge clk_sys);
		cmd_tb = 1'b0;
		wait_upd(k);
	endtask
	task wait_flag(input logic v, input int lim);
		for (int i = 0; i < lim && recal_wanted_flag !== v; i++)
			@(negedge clk_sys);
		check(recal_wanted_flag, v, "wanted flag");
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ********
	// Test sequence
	// ********
	initial begin
		{clk_sys, policy_we, frames_we, gain_high, table_change} = '0;
		{cmd_tb, avg_enable, serve_en, saw_warn, saw_shut} = '0;
		{policy_in, frames_in, cfg_high, cfg_low} = '0;
		{num_errors, n_checks, caps} = '0;
		{sensor_temp, rst} = {16'h0100, 1'b1};
		repeat (10) @(negedge clk_sys);
		check(recal_frame_count, FRAMES_SHUTTER, "reset frames");
		check(recal_policy, POL_AUTO, "reset policy");
		check(ns_frames, FRAMES_NOSHUT, "shutterless frames");
		check(ns_policy, POL_EXTERNAL, "shutterless policy");
		rst = 1'b0;
		wait_upd(n);
		check(16'(caps), 16'h0008, "startup frames");
		check(saw_warn, 1'b1, "startup warning");
		repeat (3) @(negedge clk_sys);
		check(recal_phase, PH_COMPLETE, "phase");
		$display("startup test done");
		wr(1'b1, POL_MANUAL);
		wr(1'b1, 2'h3);
		check(recal_policy, POL_MANUAL, "code 3 kept");
		for (int p = 1; p < 3; p++) begin
			wr(1'b1, 2'(p));
			run_event(n);
			check({saw_shut, saw_warn}, {p == 1, 1'b0}, "shutter use");
		end
		wr(1'b1, POL_MANUAL);
		{cfg_low, gain_high, sensor_temp} = {32'h0000_001e, 1'b1, 16'h010a};
		repeat (30) @(negedge clk_sys);
		check(recal_wanted_flag, 1'b0, "step off");
		gain_high = 1'b0;
		wait_flag(1'b1, 30);
		serve_en = 1'b1;
		wait_upd(n);
		serve_en = 1'b0;
		repeat (3) @(negedge clk_sys);
		check(recal_wanted_flag, 1'b0, "served");
		$display("policy and warm-up tests done");
		wr(1'b1, POL_AUTO);
		for (int i = 0; i < 5; i++) begin
			c = (i < 4) ? i : 3;
			wr(1'b0, 2'(c));
			avg_enable = (i == 4);
			check(recal_frame_count, 16'(2 << c), "frame code");
			run_event(d[i]);
			check(16'(caps), 16'(2 << c), "frames taken");
		end
		check(d[4] >= d[3] + 100, 1'b1, "averaged span");
		@(negedge clk_sys);
		avg_enable = 1'b0;
		{saw_warn, table_change} = 2'b01;
		@(negedge clk_sys);
		table_change = 1'b0;
		wait_upd(n);
		check(saw_warn, 1'b1, "table change");
		$display("frame tests done");
		while ($time < 12000)
			@(negedge clk_sys);
		wr(1'b1, POL_MANUAL);
		sensor_temp = 16'h011e;
		repeat (30) @(negedge clk_sys);
		check(recal_wanted_flag, 1'b0, "below step");
		sensor_temp = 16'h0128;
		wait_flag(1'b1, 20);
		cfg_low = 32'h0003_0000;
		run_event(n);
		repeat (15) @(negedge clk_sys);
		check(recal_wanted_flag, 1'b0, "early flag");
		wait_flag(1'b1, 30);
		cfg_low = 32'h0000_0000;
		run_event(n);
		repeat (60) @(negedge clk_sys);
		check(recal_wanted_flag, 1'b0, "interval off");
		check(ns_phase, PH_NEVER, "shutterless self start");
		$display("trigger tests done");
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		summarize();
	end
endmodule

// File: sec_tick.sv
// Divider giving a one-cycle pulse once per second
`timescale 1ns/1ps
module sec_tick
	import recal_pkg::*;
#(
	parameter int unsigned DIV = SEC_CYCLES
) (
	input  wire logic clk_sys, // System clock
	input  wire logic rst,     // Async reset, active high
	output logic      tick     // One-cycle pulse each period
);
	logic [31:0] cnt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt  <= 32'h0;
			tick <= 1'b0;
		end else if (cnt == 32'(DIV - 1)) begin
			cnt  <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
